// ===== common/ser_clk_pkg.sv
// Register map, field layout and codes of the serial clock configuration block.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package ser_clk_pkg;
    localparam logic [7:0] CLK_ENABLE_OFS   = 8'h0C;
    localparam logic [7:0] CLK_CONFIG_OFS   = 8'h10;
    localparam logic [7:0] RX_FLUSH_OFS     = 8'h14;
    localparam logic [7:0] TX_FLUSH_OFS     = 8'h18;
    localparam logic [7:0] PHASE_STATUS_OFS = 8'h1C;
    localparam int         WSL_LSB          = 3;
    localparam int         WSL_MSB          = 4;
    localparam int         GATE_LSB         = 0;
    localparam int         GATE_MSB         = 2;
    localparam logic [1:0] WSL_RESET        = 2'h0;
    localparam logic [2:0] GATE_RESET       = 3'h0;
    localparam logic [1:0] WSL_16           = 2'h0;
    localparam logic [1:0] WSL_24           = 2'h1;
    localparam logic [1:0] WSL_32           = 2'h2;
    localparam logic [2:0] GATE_NONE        = 3'h0;
    localparam logic [2:0] GATE_12          = 3'h1;
    localparam logic [2:0] GATE_16          = 3'h2;
    localparam logic [2:0] GATE_20          = 3'h3;
    localparam logic [2:0] GATE_24          = 3'h4;
    localparam logic [5:0] LEN_16           = 6'h10;
    localparam logic [5:0] LEN_24           = 6'h18;
    localparam logic [5:0] LEN_32           = 6'h20;
    localparam logic [5:0] CNT_12           = 6'h0C;
    localparam logic [5:0] CNT_16           = 6'h10;
    localparam logic [5:0] CNT_20           = 6'h14;
    localparam logic [5:0] CNT_24           = 6'h18;
    localparam logic [1:0] RESP_OKAY        = 2'h0;
    localparam logic [1:0] RESP_SLVERR      = 2'h2;
endpackage

// ===== dv/codec_model.sv
// Listening codec: counts serial clock rises in each word-select phase.
// Assumes it drives nothing back toward the block.
`timescale 1ns/100ps
`default_nettype none
module codec_model
(
    // Serial inputs
    input wire logic       sclk_i,
    input wire logic       ws_i,
    // Measured phase
    output var logic [6:0] len_o,
    output var logic       done_o
);
    int   cnt = 0;
    logic ws_r = 1'b0;
    initial
    begin
        len_o = 7'h00;
        done_o = 1'b0;
    end
    // Word select sampled on rising serial clock closes a phase
    always @(posedge sclk_i)
    begin
        if (ws_i !== ws_r)
        begin
            len_o = 7'(cnt);
            done_o = ~done_o;
            cnt = 0;
        end
        ws_r = ws_i;
        cnt++;
    end
endmodule
`default_nettype wire

// ===== dv/ser_clk_config_tb_top.sv
// Self-checking bench of the serial clock block with a listening codec.
// Assumes package, design, checker and codec model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module ser_clk_config_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        lclk = 1'b0;
    logic        lrst = 1'b1;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic        awv = 1'b0;
    logic        wv = 1'b0;
    logic        arv = 1'b0;
    logic        rr = 1'b0;
    logic        awr, wrdy, bv, arr, rv, sclk, ws, rxf, txf, done;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [6:0]  len;
    logic [7:0]  lfsr_s = 8'h42;
    int          failures = 0;
    int          n_tests = 0;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    logic [6:0]  pq[$];
    logic [1:0]  fq[$];
    always #2.5 clk = ~clk;
    initial
    begin
        #3.7;
        forever #15 lclk = ~lclk;
    end
    initial
    begin
        repeat (3) @(posedge lclk);
        lrst <= 1'b0;
    end
    ser_clk_config uut
    (
        .CLOCK_I(clk), .RESET_I(rst), .LINK_CLK_I(lclk), .LINK_RESET_I(lrst),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
        .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy),
        .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(1'b1),
        .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr),
        .SCLK_O(sclk), .WORD_SELECT_O(ws), .RX_FLUSH_O(rxf), .TX_FLUSH_O(txf)
    );
    codec_model u_codec (.sclk_i(sclk), .ws_i(ws), .len_o(len), .done_o(done));
    task chk(input string nm, input logic [33:0] e, input logic [33:0] g);
        n_tests++;
        if (g !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask
    task finish_test;
        if (failures == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    function automatic logic [6:0] exp_len(input logic [1:0] w, input logic [2:0] g);
        logic [5:0] l;
        logic [5:0] c;
        l = (w == ser_clk_pkg::WSL_24) ? ser_clk_pkg::LEN_24 :
            (w == ser_clk_pkg::WSL_32) ? ser_clk_pkg::LEN_32 : ser_clk_pkg::LEN_16;
        c = (g >= 3'h1 && g <= 3'h4) ? 6'(8 + 4 * g) : 6'h00;
        return 7'((c != 6'h00 && c < l) ? c : l);
    endfunction
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        @(posedge clk);
        bq.push_back(e);
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end
        while (!bv);
    endtask
    task rd(input logic [7:0] a, input logic [33:0] e);
        @(posedge clk);
        rq.push_back(e);
        araddr <= a;
        arv <= 1'b1;
        do @(posedge clk); while (!arr);
        arv <= 1'b0;
        do @(posedge clk); while (!rv);
        rr <= 1'b1;
        @(posedge clk);
        rr <= 1'b0;
    endtask
    task idle(input int n);
        repeat (n)
        begin
            @(posedge lclk);
            #1 chk("idle", 34'h0, 34'({sclk, ws}));
        end
    endtask
    task phases(input logic [1:0] w, input logic [2:0] g);
        repeat (3) @(done);
        #1;
        repeat (2) pq.push_back(exp_len(w, g));
        repeat (2) @(done);
    endtask
    always @(posedge clk)
    begin
        if (rv && rr) chk("read", rq.pop_front(), {rresp, rdata});
        if (bv) chk("bresp", 34'(bq.pop_front()), 34'(bresp));
        if (rxf || txf) chk("flush", 34'(fq.pop_front()), 34'({rxf, txf}));
    end
    always @(done)
        if (pq.size() > 0) chk("phase", 34'(pq.pop_front()), 34'(len));
    initial
    begin
        #300000;
        failures++;
        finish_test();
    end
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(ser_clk_pkg::CLK_CONFIG_OFS, 34'h0);
        rd(8'h3C, {ser_clk_pkg::RESP_SLVERR, 32'h0000_0000});
        idle(20);
        wr(ser_clk_pkg::CLK_ENABLE_OFS, 32'h0000_0001, ser_clk_pkg::RESP_OKAY);
        rd(ser_clk_pkg::CLK_ENABLE_OFS, 34'h1);
        phases(ser_clk_pkg::WSL_RESET, ser_clk_pkg::GATE_RESET);
        for (int w = 0; w < 3; w++)
            for (int g = 0; g < 5; g++)
            begin
                lfsr_s = lfsr_next(lfsr_s);
                wr(ser_clk_pkg::CLK_CONFIG_OFS, {lfsr_s, 19'h0, 2'(w), 3'(g)}, 2'h0);
                rd(ser_clk_pkg::CLK_CONFIG_OFS, {29'h0, 2'(w), 3'(g)});
                phases(2'(w), 3'(g));
            end
        fq.push_back(2'b10);
        wr(ser_clk_pkg::RX_FLUSH_OFS, 32'h0000_0001, ser_clk_pkg::RESP_OKAY);
        fq.push_back(2'b01);
        wr(ser_clk_pkg::TX_FLUSH_OFS, 32'h0000_0001, ser_clk_pkg::RESP_OKAY);
        wr(8'h3C, 32'h0000_0000, ser_clk_pkg::RESP_SLVERR);
        rd(ser_clk_pkg::RX_FLUSH_OFS, 34'h0);
        wr(ser_clk_pkg::CLK_ENABLE_OFS, 32'h0000_0000, ser_clk_pkg::RESP_OKAY);
        repeat (10) @(posedge lclk);
        idle(80);
        rd(ser_clk_pkg::PHASE_STATUS_OFS, 34'h0);
        chk("flush left", 34'h0, 34'(fq.size()));
        finish_test();
    end
endmodule
`default_nettype wire

// ===== dv/ser_clk_monitor.sv
// Checker of bus handshakes, RX flush pulses and serial clock timing.
// Assumes it is bound onto the top module of the serial clock block.
`timescale 1ns/100ps
`default_nettype none
module ser_clk_monitor
(
    // Clocks and resets
    input wire logic        CLOCK_I,
    input wire logic        RESET_I,
    input wire logic        LINK_CLK_I,
    input wire logic        LINK_RESET_I,
    // Bus handshakes
    input wire logic        S_AXI_AWVALID_I,
    input wire logic        S_AXI_AWREADY_O,
    input wire logic        S_AXI_WVALID_I,
    input wire logic        S_AXI_WREADY_O,
    input wire logic        S_AXI_BVALID_O,
    input wire logic        S_AXI_ARVALID_I,
    input wire logic        S_AXI_ARREADY_O,
    input wire logic [31:0] S_AXI_RDATA_O,
    input wire logic        S_AXI_RVALID_O,
    input wire logic        S_AXI_RREADY_I,
    // Serial and flush outputs
    input wire logic        SCLK_O,
    input wire logic        WORD_SELECT_O,
    input wire logic        RX_FLUSH_O
);
    logic [5:0] rise_r;
    logic       sclk_d_r;
    logic       ws_d_r;
    // Serial clock rises since the last word-select edge
    always_ff @(posedge LINK_CLK_I)
    begin
        sclk_d_r <= SCLK_O;
        ws_d_r <= WORD_SELECT_O;
        if (LINK_RESET_I || (WORD_SELECT_O != ws_d_r))
            rise_r <= 6'h00;
        else if (SCLK_O && !sclk_d_r)
            rise_r <= rise_r + 6'h01;
    end
    a_b_after_w: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O)
        |-> ##2 S_AXI_BVALID_O) else $error("write response late");
    a_r_after_ar: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O) else $error("read data late");
    a_aw_blocked: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O) else $error("write open");
    a_ar_blocked: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        S_AXI_RVALID_O |-> !S_AXI_ARREADY_O) else $error("read address open");
    a_r_holds: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
        else $error("read data dropped");
    a_flush_pulse: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
        RX_FLUSH_O |=> !RX_FLUSH_O) else $error("flush pulse too long");
    a_sclk_high: assert property (@(posedge LINK_CLK_I) disable iff (LINK_RESET_I)
        $rose(SCLK_O) |=> $fell(SCLK_O)) else $error("serial clock high too long");
    a_phase_max: assert property (@(posedge LINK_CLK_I) disable iff (LINK_RESET_I)
        rise_r <= 6'h20) else $error("word select phase too long");
endmodule
bind ser_clk_config ser_clk_monitor u_mon
(
    .CLOCK_I(CLOCK_I), .RESET_I(RESET_I), .LINK_CLK_I(LINK_CLK_I), .LINK_RESET_I(LINK_RESET_I),
    .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
    .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O),
    .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
    .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RDATA_O(S_AXI_RDATA_O),
    .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
    .SCLK_O(SCLK_O), .WORD_SELECT_O(WORD_SELECT_O), .RX_FLUSH_O(RX_FLUSH_O)
);
`default_nettype wire

// ===== hw/ser_clk_config.sv
// AXI4-Lite register front end and clock domain crossing for the serial clock block.
// Assumes one outstanding read and one outstanding write from the master.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Length field picks 16, 24, 32 cycles
// - Gating field picks cutoff 12/16/20/24 or none
// - Word select alternates left and right phases
// - Both fields reset to zero
// - Code zero keeps serial clock always toggling
module ser_clk_config
(
    // System clock and reset
    input  wire logic        CLOCK_I,
    input  wire logic        RESET_I,
    // Link clock and reset
    input  wire logic        LINK_CLK_I,
    input  wire logic        LINK_RESET_I,
    // AXI4-Lite write address
    input  wire logic [7:0]  S_AXI_AWADDR_I,
    input  wire logic        S_AXI_AWVALID_I,
    output logic             S_AXI_AWREADY_O,
    // AXI4-Lite write data
    input  wire logic [31:0] S_AXI_WDATA_I,
    input  wire logic [3:0]  S_AXI_WSTRB_I,
    input  wire logic        S_AXI_WVALID_I,
    output logic             S_AXI_WREADY_O,
    // AXI4-Lite write response
    output logic [1:0]       S_AXI_BRESP_O,
    output logic             S_AXI_BVALID_O,
    input  wire logic        S_AXI_BREADY_I,
    // AXI4-Lite read address
    input  wire logic [7:0]  S_AXI_ARADDR_I,
    input  wire logic        S_AXI_ARVALID_I,
    output logic             S_AXI_ARREADY_O,
    // AXI4-Lite read data
    output logic [31:0]      S_AXI_RDATA_O,
    output logic [1:0]       S_AXI_RRESP_O,
    output logic             S_AXI_RVALID_O,
    input  wire logic        S_AXI_RREADY_I,
    // Serial link outputs
    output logic             SCLK_O,
    output logic             WORD_SELECT_O,
    // Flush strobes toward the sample buffers
    output logic             RX_FLUSH_O,
    output logic             TX_FLUSH_O
);
    logic        clk_en_r;
    logic [1:0]  wsl_r;
    logic [2:0]  gate_r;
    logic        aw_got_r;
    logic        w_got_r;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    logic        rx_flush_r;
    logic        tx_flush_r;
    // Link domain synchronisers
    logic        run_s1_r;
    logic        run_s2_r;
    logic [4:0]  cfg_s1_r;
    logic [4:0]  cfg_s2_r;
    logic [4:0]  cfg_s3_r;
    logic [4:0]  cfg_link_r;
    logic        right_link;
    // System domain synchroniser of the phase flag
    logic        ph_s1_r;
    logic        ph_s2_r;

    wire       aw_hs    = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
    wire       w_hs     = S_AXI_WVALID_I && S_AXI_WREADY_O;
    wire       ar_hs    = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
    wire       do_write = aw_got_r && w_got_r && !bvalid_r;
    wire       wr_en    = do_write && awaddr_r[7:2] == ser_clk_pkg::CLK_ENABLE_OFS[7:2];
    wire       wr_cfg   = do_write && awaddr_r[7:2] == ser_clk_pkg::CLK_CONFIG_OFS[7:2];
    wire       wr_rxf   = do_write && awaddr_r[7:2] == ser_clk_pkg::RX_FLUSH_OFS[7:2];
    wire       wr_txf   = do_write && awaddr_r[7:2] == ser_clk_pkg::TX_FLUSH_OFS[7:2];
    wire       wr_hit   = wr_en || wr_cfg || wr_rxf || wr_txf;
    wire [5:0] ra       = S_AXI_ARADDR_I[7:2];
    wire       rd_en    = ra == ser_clk_pkg::CLK_ENABLE_OFS[7:2];
    wire       rd_cfg   = ra == ser_clk_pkg::CLK_CONFIG_OFS[7:2];
    wire       rd_flush = ra == ser_clk_pkg::RX_FLUSH_OFS[7:2]
                       || ra == ser_clk_pkg::TX_FLUSH_OFS[7:2];
    wire       rd_stat  = ra == ser_clk_pkg::PHASE_STATUS_OFS[7:2];
    wire       rd_hit   = rd_en || rd_cfg || rd_flush || rd_stat;
    wire [31:0] rd_mux  = rd_en   ? {31'h0000_0000, clk_en_r} :
                          rd_cfg  ? {27'h000_0000, wsl_r, gate_r} :
                          rd_stat ? {31'h0000_0000, ph_s2_r} :
                          32'h0000_0000;

    assign S_AXI_AWREADY_O = !aw_got_r;
    assign S_AXI_WREADY_O  = !w_got_r;
    assign S_AXI_BVALID_O  = bvalid_r;
    assign S_AXI_BRESP_O   = bresp_r;
    assign S_AXI_ARREADY_O = !rvalid_r;
    assign S_AXI_RVALID_O  = rvalid_r;
    assign S_AXI_RDATA_O   = rdata_r;
    assign S_AXI_RRESP_O   = rresp_r;
    assign RX_FLUSH_O      = rx_flush_r;
    assign TX_FLUSH_O      = tx_flush_r;

    // Write channels, taken in either order
    always_ff @(posedge CLOCK_I)
    begin
        if (RESET_I)
        begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r  <= 32'h0000_0000;
            wstrb_r  <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r  <= ser_clk_pkg::RESP_OKAY;
        end
        else
        begin
            if (aw_hs)
            begin
                aw_got_r <= 1'b1;
                awaddr_r <= S_AXI_AWADDR_I;
            end
            if (w_hs)
            begin
                w_got_r <= 1'b1;
                wdata_r <= S_AXI_WDATA_I;
                wstrb_r <= S_AXI_WSTRB_I;
            end
            if (do_write)
            begin
                bvalid_r <= 1'b1;
                bresp_r  <= wr_hit ? ser_clk_pkg::RESP_OKAY : ser_clk_pkg::RESP_SLVERR;
            end
            else if (bvalid_r && S_AXI_BREADY_I)
            begin
                bvalid_r <= 1'b0;
                aw_got_r <= 1'b0;
                w_got_r  <= 1'b0;
            end
        end
    end

    // Register storage and flush strobes
    always_ff @(posedge CLOCK_I)
    begin
        if (RESET_I)
        begin
            clk_en_r   <= 1'b0;
            wsl_r      <= ser_clk_pkg::WSL_RESET;
            gate_r     <= ser_clk_pkg::GATE_RESET;
            rx_flush_r <= 1'b0;
            tx_flush_r <= 1'b0;
        end
        else
        begin
            rx_flush_r <= wr_rxf && wstrb_r[0] && wdata_r[0];
            tx_flush_r <= wr_txf && wstrb_r[0] && wdata_r[0];
            if (wr_en && wstrb_r[0])
            begin
                clk_en_r <= wdata_r[0];
            end
            if (wr_cfg && wstrb_r[0])
            begin
                wsl_r  <= wdata_r[ser_clk_pkg::WSL_MSB:ser_clk_pkg::WSL_LSB];
                gate_r <= wdata_r[ser_clk_pkg::GATE_MSB:ser_clk_pkg::GATE_LSB];
            end
        end
    end

    // Read channel
    always_ff @(posedge CLOCK_I)
    begin
        if (RESET_I)
        begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= ser_clk_pkg::RESP_OKAY;
        end
        else if (ar_hs)
        begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_mux;
            rresp_r  <= rd_hit ? ser_clk_pkg::RESP_OKAY : ser_clk_pkg::RESP_SLVERR;
        end
        else if (rvalid_r && S_AXI_RREADY_I)
        begin
            rvalid_r <= 1'b0;
        end
    end

    // Settings into the link domain; fields change only while idle or between phases
    always_ff @(posedge LINK_CLK_I)
    begin
        if (LINK_RESET_I)
        begin
            run_s1_r <= 1'b0;
            run_s2_r <= 1'b0;
            cfg_s1_r <= 5'h00;
            cfg_s2_r <= 5'h00;
        end
        else
        begin
            run_s1_r <= clk_en_r;
            run_s2_r <= run_s1_r;
            cfg_s1_r <= {wsl_r, gate_r};
            cfg_s2_r <= cfg_s1_r;
        end
    end

    // Settings word passed on after two equal samples only
    // Bits of one word may resolve a link cycle apart; a mixed word never lasts two cycles
    // Software must leave a few link cycles between two writes of the settings
    always_ff @(posedge LINK_CLK_I)
    begin
        if (LINK_RESET_I)
        begin
            cfg_s3_r   <= 5'h00;
            cfg_link_r <= {ser_clk_pkg::WSL_RESET, ser_clk_pkg::GATE_RESET};
        end
        else
        begin
            cfg_s3_r <= cfg_s2_r;
            if (cfg_s2_r == cfg_s3_r)
            begin
                cfg_link_r <= cfg_s3_r;
            end
        end
    end

    // Current phase back into the system domain
    always_ff @(posedge CLOCK_I)
    begin
        if (RESET_I)
        begin
            ph_s1_r <= 1'b0;
            ph_s2_r <= 1'b0;
        end
        else
        begin
            ph_s1_r <= right_link;
            ph_s2_r <= ph_s1_r;
        end
    end

    ser_clk_phase_gen u_phase_gen
    (
        .link_clk_i (LINK_CLK_I),
        .link_rst_i (LINK_RESET_I),
        .run_i      (run_s2_r),
        .wsl_i      (cfg_link_r[4:3]),
        .gate_i     (cfg_link_r[2:0]),
        .sclk_o     (SCLK_O),
        .ws_o       (WORD_SELECT_O),
        .right_o    (right_link)
    );
endmodule
`default_nettype wire

// ===== hw/ser_clk_phase_gen.sv
// Link-side generator of serial clock and word select, on the link clock.
// Assumes settings are stable when sampled at a phase boundary.
`timescale 1ns/100ps
`default_nettype none
module ser_clk_phase_gen
(
    // Link clock and reset
    input  wire logic       link_clk_i,
    input  wire logic       link_rst_i,
    // Settings, already synchronised
    input  wire logic       run_i,
    input  wire logic [1:0] wsl_i,
    input  wire logic [2:0] gate_i,
    // Serial outputs
    output logic            sclk_o,
    output logic            ws_o,
    output logic            right_o
);
    logic [5:0] cnt_r;
    logic       half_r;
    logic       ws_r;
    logic [1:0] wsl_r;
    logic [2:0] gate_r;
    logic [5:0] len;
    logic [5:0] gate_at;
    logic       last_cycle;
    logic       gated;

    assign len = (wsl_r == ser_clk_pkg::WSL_24) ? ser_clk_pkg::LEN_24 :
                 (wsl_r == ser_clk_pkg::WSL_32) ? ser_clk_pkg::LEN_32 :
                 ser_clk_pkg::LEN_16;
    assign gate_at = (gate_r == ser_clk_pkg::GATE_12) ? ser_clk_pkg::CNT_12 :
                     (gate_r == ser_clk_pkg::GATE_16) ? ser_clk_pkg::CNT_16 :
                     (gate_r == ser_clk_pkg::GATE_20) ? ser_clk_pkg::CNT_20 :
                     (gate_r == ser_clk_pkg::GATE_24) ? ser_clk_pkg::CNT_24 :
                     6'h3F;
    assign gated = (gate_r != ser_clk_pkg::GATE_NONE) && (cnt_r >= gate_at);
    assign last_cycle = half_r && (cnt_r == len - 6'h01);

    // One serial clock cycle is two link clock cycles
    always_ff @(posedge link_clk_i)
    begin
        if (link_rst_i || !run_i)
        begin
            cnt_r  <= 6'h00;
            half_r <= 1'b0;
            ws_r   <= 1'b0;
            wsl_r  <= ser_clk_pkg::WSL_RESET;
            gate_r <= ser_clk_pkg::GATE_RESET;
            if (!link_rst_i)
            begin
                wsl_r  <= wsl_i;
                gate_r <= gate_i;
            end
        end
        else
        begin
            half_r <= ~half_r;
            if (last_cycle)
            begin
                cnt_r  <= 6'h00;
                ws_r   <= ~ws_r;
                wsl_r  <= wsl_i;
                gate_r <= gate_i;
            end
            else if (half_r)
            begin
                cnt_r <= cnt_r + 6'h01;
            end
        end
    end

    always_ff @(posedge link_clk_i)
    begin
        if (link_rst_i)
        begin
            sclk_o <= 1'b0;
            ws_o   <= 1'b0;
        end
        else
        begin
            sclk_o <= run_i && half_r == 1'b0 && !gated;
            // Word select moves with the falling serial clock edge
            ws_o   <= run_i && (ws_r ^ last_cycle);
        end
    end

    assign right_o = ws_r;
endmodule
`default_nettype wire
